// ==== inc/art_pkg.sv ====
// package of the auto-reload timer: register offsets, field positions,
// reset values and widths shared by the timer and its prescaler.
// assumes a byte-wide register port with an 8-bit address.

package art_pkg;

   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int ART_AW       = 8;
   localparam int ART_DW       = 8;
   localparam int ART_CW       = 16;
   localparam int ART_PSW      = 3;
   localparam int ART_PCW      = 7;
   localparam int ART_NEVT     = 2;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] ART_OFS_CTRL   = 8'hC4;
   localparam logic [7:0] ART_OFS_RLD_LO = 8'hC5;
   localparam logic [7:0] ART_OFS_RLD_HI = 8'hC6;
   localparam logic [7:0] ART_OFS_IEN    = 8'hC7;
   localparam logic [7:0] ART_OFS_STAT   = 8'hC8;
   localparam logic [7:0] ART_OFS_MASK   = 8'hC9;
   localparam logic [7:0] ART_OFS_CNT_LO = 8'hCA;
   localparam logic [7:0] ART_OFS_CNT_HI = 8'hCB;

   // ---------------------------------------------------------------
   // control register fields
   // ---------------------------------------------------------------
   localparam int ART_PS_LSB   = 0;
   localparam int ART_PS_MSB   = 2;
   localparam int ART_RUN_BIT  = 3;
   localparam int ART_OVF_BIT  = 4;
   localparam int ART_BAUD_CLOCK_SELECT_BIT_BIT = 5;
   localparam int ART_FRM_BIT  = 6;
   localparam int ART_DBL_BIT  = 7;

   // interrupt enable register field
   localparam int ART_TIE_BIT  = 1;

   // status / mask bit positions
   localparam int ART_EVT_OVF  = 0;
   localparam int ART_EVT_RLW  = 1;

   // ---------------------------------------------------------------
   // reset values and count constants
   // ---------------------------------------------------------------
   localparam logic [7:0]  ART_RST_BYTE = 8'h00;
   localparam logic [15:0] ART_RST_CNT  = 16'h0000;
   localparam logic [15:0] ART_CNT_MAX  = 16'hFFFF;
   localparam logic [15:0] ART_CNT_ONE  = 16'h0001;
   localparam logic [6:0]  ART_PC_ZERO  = 7'h00;
   localparam logic [6:0]  ART_PC_ONE   = 7'h01;

endpackage

// ==== rtl/art_prescaler.sv ====
// prescaler of the auto-reload timer: a free counter on the system
// clock whose low bits, selected by the prescale code, form the tick.
// assumes the caller holds run low to clear it while the timer halts.
`timescale 1ns/1ps

module art_prescaler #(
   parameter int PSW = art_pkg::ART_PSW,   // prescale code width
   parameter int PCW = art_pkg::ART_PCW    // divider counter width
) (
   input  wire logic           clk_sys,    // system clock
   input  wire logic           sys_rst,    // sync reset, high
   input  wire logic           run,        // timer running
   input  wire logic [PSW-1:0] sel,        // divide by 2**sel
   output logic                tick        // one-cycle count pulse
);
   import art_pkg::*;

   logic [PCW-1:0] div_ff;
   logic [PCW-1:0] nxt_div;
   logic [PCW-1:0] sel_mask;

   // ---------------------------------------------------------------
   // tick decode
   // ---------------------------------------------------------------
   // mask of the low sel bits; all-ones there marks the last count,
   // so code 0 ticks every cycle and code 7 every 128 cycles
   always_comb begin
      sel_mask = PCW'((PCW'(ART_PC_ONE) << sel) - PCW'(ART_PC_ONE));
      tick     = run && ((div_ff & sel_mask) == sel_mask);
   end

   // ---------------------------------------------------------------
   // divider counter
   // ---------------------------------------------------------------
   // cleared while halted so the first period after start is whole
   always_comb begin
      if (!run) begin
         nxt_div = PCW'(ART_PC_ZERO);
      end else if (tick) begin
         nxt_div = PCW'(ART_PC_ZERO);
      end else begin
         nxt_div = PCW'(div_ff + PCW'(ART_PC_ONE));
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         div_ff <= PCW'(ART_PC_ZERO);
      end else begin
         div_ff <= nxt_div;
      end
   end

endmodule

// ==== rtl/art_timer.sv ====
// 16-bit up-counting timer with automatic reload, a prescaler, an
// overflow flag with interrupt request and a baud tick for the uarts.
// assumes a single-cycle byte register port on the system clock and a
// one-cycle pulse from the cpu when it enters the timer service routine.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps

module art_timer #(
   parameter int CW   = art_pkg::ART_CW,     // counter width
   parameter int NEVT = art_pkg::ART_NEVT    // status event count
) (
   input  wire logic                      clk_sys,     // system clock
   input  wire logic                      sys_rst,     // sync reset
   input  wire logic [art_pkg::ART_AW-1:0] reg_addr,   // register address
   input  wire logic [art_pkg::ART_DW-1:0] reg_wdata,  // write data
   input  wire logic                      reg_wr,      // write strobe
   input  wire logic                      reg_rd,      // read strobe
   output logic      [art_pkg::ART_DW-1:0] reg_rdata,  // read data, +1
   input  wire logic                      isr_enter,   // cpu enters isr
   output logic                           timer_irq,   // timer request
   output logic                           irq,         // status irq
   output logic                           baud_tick,   // overflow pulse
   output logic                           serial_double_rate_bit, // bit 7
   output logic                           serial_framing_select_bit, // bit 6
   output logic                           baud_clock_select_bit // bit 5
);
   import art_pkg::*;

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic [ART_PSW-1:0] prescale_select_ff;
   logic               run_control_bit_ff;
   logic               overflow_flag_ff;
   logic [2:0]         serial_bits_ff;
   logic [ART_DW-1:0]  reload_low_byte_ff;
   logic [ART_DW-1:0]  reload_high_byte_ff;
   logic               timer_interrupt_enable_ff;
   logic [NEVT-1:0]    stat_ff;
   logic [NEVT-1:0]    mask_ff;
   logic [CW-1:0]      count_ff;
   logic [ART_DW-1:0]  rdata_ff;
   logic               timer_irq_ff;
   logic               irq_ff;
   logic               baud_tick_ff;

   // next values and decodes
   logic               nxt_overflow_flag;
   logic [CW-1:0]      nxt_count;
   logic [NEVT-1:0]    nxt_stat;
   logic [NEVT-1:0]    evt;
   logic [ART_DW-1:0]  nxt_rdata;
   logic               wr_ctrl;
   logic               wr_rld_lo;
   logic               wr_rld_hi;
   logic               wr_ien;
   logic               wr_stat;
   logic               wr_mask;
   logic               step;
   logic               wrap;
   logic [CW-1:0]      reload_value;

   // ---------------------------------------------------------------
   // write decode
   // ---------------------------------------------------------------
   // one decode per writable register; an unmapped write touches nothing
   always_comb begin
      wr_ctrl   = reg_wr && (reg_addr == ART_OFS_CTRL);
      wr_rld_lo = reg_wr && (reg_addr == ART_OFS_RLD_LO);
      wr_rld_hi = reg_wr && (reg_addr == ART_OFS_RLD_HI);
      wr_ien    = reg_wr && (reg_addr == ART_OFS_IEN);
      wr_stat   = reg_wr && (reg_addr == ART_OFS_STAT);
      wr_mask   = reg_wr && (reg_addr == ART_OFS_MASK);
   end

   // ---------------------------------------------------------------
   // prescaler
   // ---------------------------------------------------------------
   // the divider runs only with the run bit; halting clears it
   art_prescaler #(
      .PSW (ART_PSW),
      .PCW (ART_PCW)
   ) u_prescaler (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .run     (run_control_bit_ff),
      .sel     (prescale_select_ff),
      .tick    (step)
   );

   // ---------------------------------------------------------------
   // control register
   // ---------------------------------------------------------------
   // prescale, run and the three uart bits are plain storage
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         prescale_select_ff <= ART_PSW'(ART_RST_BYTE);
         run_control_bit_ff <= 1'b0;
         serial_bits_ff     <= 3'(ART_RST_BYTE);
      end else if (wr_ctrl) begin
         prescale_select_ff <= reg_wdata[ART_PS_MSB:ART_PS_LSB];
         run_control_bit_ff <= reg_wdata[ART_RUN_BIT];
         serial_bits_ff     <= reg_wdata[ART_DBL_BIT:ART_BAUD_CLOCK_SELECT_BIT_BIT];
      end
   end

   // ---------------------------------------------------------------
   // reload bytes
   // ---------------------------------------------------------------
   // written regardless of run; software keeps writes to halted
   // periods, otherwise the next reload may see a torn value
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         reload_low_byte_ff <= ART_RST_BYTE;
      end else if (wr_rld_lo) begin
         reload_low_byte_ff <= reg_wdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         reload_high_byte_ff <= ART_RST_BYTE;
      end else if (wr_rld_hi) begin
         reload_high_byte_ff <= reg_wdata;
      end
   end

   assign reload_value = {reload_high_byte_ff, reload_low_byte_ff};

   // ---------------------------------------------------------------
   // counter
   // ---------------------------------------------------------------
   // steps only on a prescaler pulse, which never comes while halted;
   // at the top it takes the reload value instead of wrapping to zero
   always_comb begin
      wrap = step && (count_ff == CW'(ART_CNT_MAX));
      if (wrap) begin
         nxt_count = reload_value;
      end else if (step && run_control_bit_ff) begin
         nxt_count = CW'(count_ff + CW'(ART_CNT_ONE));
      end else begin
         nxt_count = count_ff;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         count_ff <= CW'(ART_RST_CNT);
      end else begin
         count_ff <= nxt_count;
      end
   end

   // ---------------------------------------------------------------
   // overflow flag
   // ---------------------------------------------------------------
   // a software write or the isr entry may clear it, but an overflow
   // in the same cycle wins so that no overflow is ever lost
   always_comb begin
      nxt_overflow_flag = overflow_flag_ff;
      if (isr_enter) begin
         nxt_overflow_flag = 1'b0;
      end
      if (wr_ctrl) begin
         nxt_overflow_flag = reg_wdata[ART_OVF_BIT];
      end
      if (wrap) begin
         nxt_overflow_flag = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         overflow_flag_ff <= 1'b0;
      end else begin
         overflow_flag_ff <= nxt_overflow_flag;
      end
   end

   // ---------------------------------------------------------------
   // timer interrupt enable
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         timer_interrupt_enable_ff <= 1'b0;
      end else if (wr_ien) begin
         timer_interrupt_enable_ff <= reg_wdata[ART_TIE_BIT];
      end
   end

   // request follows the next flag so it carries no extra cycle of lag
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         timer_irq_ff <= 1'b0;
      end else if (wr_ien) begin
         timer_irq_ff <= nxt_overflow_flag && reg_wdata[ART_TIE_BIT];
      end else begin
         timer_irq_ff <= nxt_overflow_flag &&
                         timer_interrupt_enable_ff;
      end
   end

   // ---------------------------------------------------------------
   // event status and mask
   // ---------------------------------------------------------------
   // events: overflow, and a reload byte written while running
   always_comb begin
      evt              = '0;
      evt[ART_EVT_OVF] = wrap;
      evt[ART_EVT_RLW] = (wr_rld_lo || wr_rld_hi) &&
                         run_control_bit_ff;
   end

   // sticky bits, write one to clear; a new event beats the clear
   genvar gi;
   generate
      for (gi = 0; gi < NEVT; gi++) begin : g_stat
         always_comb begin
            if (evt[gi]) begin
               nxt_stat[gi] = 1'b1;
            end else if (wr_stat && reg_wdata[gi]) begin
               nxt_stat[gi] = 1'b0;
            end else begin
               nxt_stat[gi] = stat_ff[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         stat_ff <= NEVT'(ART_RST_BYTE);
      end else begin
         stat_ff <= nxt_stat;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         mask_ff <= NEVT'(ART_RST_BYTE);
      end else if (wr_mask) begin
         mask_ff <= reg_wdata[NEVT-1:0];
      end
   end

   // level output, high while any unmasked status bit stands
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         irq_ff <= 1'b0;
      end else if (wr_mask) begin
         irq_ff <= |(nxt_stat & reg_wdata[NEVT-1:0]);
      end else begin
         irq_ff <= |(nxt_stat & mask_ff);
      end
   end

   // ---------------------------------------------------------------
   // baud tick
   // ---------------------------------------------------------------
   // one pulse per overflow; the uarts pick it by their own select bit
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         baud_tick_ff <= 1'b0;
      end else begin
         baud_tick_ff <= wrap;
      end
   end

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   // data stand one cycle after the strobe and read as zero otherwise
   always_comb begin
      nxt_rdata = ART_RST_BYTE;
      if (reg_rd) begin
         case (reg_addr)
            ART_OFS_CTRL: begin
               nxt_rdata = {serial_bits_ff, overflow_flag_ff,
                            run_control_bit_ff, prescale_select_ff};
            end
            ART_OFS_RLD_LO: begin
               nxt_rdata = reload_low_byte_ff;
            end
            ART_OFS_RLD_HI: begin
               nxt_rdata = reload_high_byte_ff;
            end
            ART_OFS_IEN: begin
               nxt_rdata[ART_TIE_BIT] = timer_interrupt_enable_ff;
            end
            ART_OFS_STAT: begin
               nxt_rdata[NEVT-1:0] = stat_ff;
            end
            ART_OFS_MASK: begin
               nxt_rdata[NEVT-1:0] = mask_ff;
            end
            ART_OFS_CNT_LO: begin
               nxt_rdata = count_ff[ART_DW-1:0];
            end
            ART_OFS_CNT_HI: begin
               nxt_rdata = count_ff[CW-1:ART_DW];
            end
            default: begin
               nxt_rdata = ART_RST_BYTE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rdata_ff <= ART_RST_BYTE;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // all straight from flip-flops
   assign reg_rdata                 = rdata_ff;
   assign timer_irq                 = timer_irq_ff;
   assign irq                       = irq_ff;
   assign baud_tick                 = baud_tick_ff;
   assign serial_double_rate_bit    = serial_bits_ff[2];
   assign serial_framing_select_bit = serial_bits_ff[1];
   assign baud_clock_select_bit     = serial_bits_ff[0];

endmodule

// ==== tb/art_timer_sva.sv ====
// checker of the auto-reload timer: interrupt, flag and uart bit rules.
// assumes it is bound to art_timer and sees only the top module's ports.
`timescale 1ns/1ps

module art_timer_sva #(
   parameter int CW   = art_pkg::ART_CW,     // counter width
   parameter int NEVT = art_pkg::ART_NEVT    // status event count
) (
   input wire logic                       clk_sys,    // system clock
   input wire logic                       sys_rst,    // sync reset
   input wire logic [art_pkg::ART_AW-1:0] reg_addr,   // register address
   input wire logic [art_pkg::ART_DW-1:0] reg_wdata,  // write data
   input wire logic                       reg_wr,     // write strobe
   input wire logic                       reg_rd,     // read strobe
   input wire logic [art_pkg::ART_DW-1:0] reg_rdata,  // read data
   input wire logic                       isr_enter,  // cpu enters isr
   input wire logic                       timer_irq,  // timer request
   input wire logic                       irq,        // status irq
   input wire logic                       baud_tick,  // overflow pulse
   input wire logic                       serial_double_rate_bit, // bit 7
   input wire logic                       serial_framing_select_bit, // bit 6
   input wire logic                       baud_clock_select_bit // bit 5
);
   import art_pkg::*;

   // ---------------------------------------------------------------
   // shadow of the software-written bits
   // ---------------------------------------------------------------
   logic       ctl_wr;
   logic       en_ff;
   logic       run_ff;
   logic [1:0] mask_ff;
   logic [2:0] uwr_ff;

   assign ctl_wr = reg_wr && (reg_addr == ART_OFS_CTRL);

   // tracks the write edge itself, so no lag against the design's level
   always_ff @(posedge clk_sys) begin
      uwr_ff <= reg_wdata[7:5];
      if (sys_rst) begin
         en_ff   <= 1'b0;
         run_ff  <= 1'b0;
         mask_ff <= 2'h0;
      end else if (reg_wr) begin
         if (reg_addr == ART_OFS_IEN) en_ff <= reg_wdata[ART_TIE_BIT];
         if (reg_addr == ART_OFS_CTRL) run_ff <= reg_wdata[ART_RUN_BIT];
         if (reg_addr == ART_OFS_MASK) mask_ff <= reg_wdata[1:0];
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   AST_IRQ_ON_OVF: assert property (baud_tick && en_ff |-> timer_irq)
      else $error("timer request missing on overflow");
   AST_IRQ_NEEDS_EN: assert property (!en_ff |-> !timer_irq)
      else $error("timer request while disabled");
   AST_ISR_CLEARS: assert property (isr_enter |=>
      !timer_irq || baud_tick) else $error("flag survived service entry");
   AST_SW_SET: assert property (ctl_wr && reg_wdata[ART_OVF_BIT] |=>
      timer_irq == en_ff) else $error("software set of flag lost");
   AST_SW_CLR: assert property (ctl_wr && !reg_wdata[ART_OVF_BIT] |=>
      timer_irq == (baud_tick && en_ff)) else $error("flag not cleared");
   AST_UART_BITS: assert property (ctl_wr |=>
      {serial_double_rate_bit, serial_framing_select_bit,
       baud_clock_select_bit} == uwr_ff) else $error("uart bits wrong");
   AST_HALT_QUIET: assert property (!run_ff && !$past(run_ff) |->
      !baud_tick) else $error("overflow while halted");
   AST_IRQ_STATUS: assert property (baud_tick &&
      mask_ff[ART_EVT_OVF] |-> irq)
      else $error("status irq missing on overflow");

   // main scenarios reached
   COV_OVF_IRQ: cover property (baud_tick && timer_irq);
   COV_ISR: cover property (isr_enter ##1 !timer_irq);
   COV_STAT: cover property (irq && !timer_irq);

endmodule

bind art_timer art_timer_sva #(.CW(CW), .NEVT(NEVT)) u_art_timer_sva (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .isr_enter(isr_enter), .timer_irq(timer_irq),
   .irq(irq), .baud_tick(baud_tick),
   .serial_double_rate_bit(serial_double_rate_bit),
   .serial_framing_select_bit(serial_framing_select_bit),
   .baud_clock_select_bit(baud_clock_select_bit));

// ==== tb/tb_art_timer.sv ====
// testbench of the auto-reload timer: register port, prescaler sweep,
// reload, flag and interrupt handling, read results checked from a queue.
// assumes the timer's checker is bound in from its own file.
`timescale 1ns/1ps

module tb_art_timer;
   import art_pkg::*;

   logic       clk_sys;
   logic       sys_rst;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic       isr_enter;
   logic       timer_irq;
   logic       irq;
   logic       baud_tick;
   logic [2:0] ubits;
   logic       rd_q;
   logic [7:0] exp_q[$];
   int         fail_count;
   int         cmp_count;

   art_timer u_art_timer (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .isr_enter(isr_enter), .timer_irq(timer_irq),
      .irq(irq), .baud_tick(baud_tick),
      .serial_double_rate_bit(ubits[2]),
      .serial_framing_select_bit(ubits[1]),
      .baud_clock_select_bit(ubits[0]));

   // ---------------------------------------------------------------
   // clock, compare and closing tasks
   // ---------------------------------------------------------------
   always #2 clk_sys = ~clk_sys;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // bus master; a spare cycle after each strobe avoids double drives
   // ---------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      exp_q.push_back(exp);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(posedge clk_sys);
   endtask

   // counts edges up to the next sampled overflow pulse, bounded
   task automatic wait_tick(output int n);
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (baud_tick !== 1'b1 && n < 70000);
      if (n >= 70000) fail_count++;
   endtask

   task automatic isr_pulse;
      isr_enter <= 1'b1;
      @(posedge clk_sys);
      isr_enter <= 1'b0;
      @(posedge clk_sys);
   endtask

   // read data stand only in the cycle after the strobe
   always @(posedge clk_sys) begin
      if (rd_q) begin
         if (exp_q.size() == 0) fail_count++;
         else check(reg_rdata, exp_q.pop_front());
      end
      rd_q <= reg_rd;
   end

   // hang guard: the longest run is one full count from zero
   initial begin
      repeat (95000) @(posedge clk_sys);
      fail_count++;
      tally_and_finish();
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [7:0] lo;
      logic [7:0] hi;
      logic [7:0] u;
      int         g;
      clk_sys    = 1'b0;
      sys_rst    = 1'b1;
      reg_addr   = 8'h00;
      reg_wdata  = 8'h00;
      reg_wr     = 1'b0;
      reg_rd     = 1'b0;
      isr_enter  = 1'b0;
      fail_count = 0;
      cmp_count  = 0;
      void'($urandom(32'h3EAAB1BB));
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      rd(ART_OFS_RLD_LO, 8'h00);
      rd(ART_OFS_RLD_HI, 8'h00);
      rd(ART_OFS_CNT_LO, 8'h00);
      check(ubits, 3'h0);
      wr(8'h10, 8'hAA);
      rd(8'h10, 8'h00);
      // random reload bytes and uart bits, timer halted throughout
      repeat (4) begin
         lo = $urandom;
         hi = $urandom;
         u  = $urandom;
         wr(ART_OFS_RLD_LO, lo);
         wr(ART_OFS_RLD_HI, hi);
         wr(ART_OFS_CTRL, {u[2:0], 5'h00});
         rd(ART_OFS_RLD_LO, lo);
         rd(ART_OFS_RLD_HI, hi);
         rd(ART_OFS_CTRL, {u[2:0], 5'h00});
         check(ubits, u[2:0]);
      end
      // full count from zero, then a slow lap to halt right on reload
      wr(ART_OFS_CTRL, 8'h00);
      wr(ART_OFS_IEN, 8'h02);
      wr(ART_OFS_MASK, 8'h01);
      wr(ART_OFS_RLD_LO, 8'hF0);
      wr(ART_OFS_RLD_HI, 8'hFF);
      wr(ART_OFS_CTRL, 8'h08);
      wait_tick(g);
      wr(ART_OFS_CTRL, 8'h1F);
      wait_tick(g);
      wr(ART_OFS_CTRL, 8'h17);
      rd(ART_OFS_CNT_LO, 8'hF0);
      rd(ART_OFS_CNT_HI, 8'hFF);
      check(timer_irq, 1'b1);
      check(irq, 1'b1);
      isr_pulse();
      check(timer_irq, 1'b0);
      check(irq, 1'b1);
      rd(ART_OFS_CTRL, 8'h07);
      wr(ART_OFS_STAT, 8'h01);
      check(irq, 1'b0);
      // software set and clear of the flag, with and without enable
      wr(ART_OFS_CTRL, 8'h17);
      check(timer_irq, 1'b1);
      wr(ART_OFS_IEN, 8'h00);
      check(timer_irq, 1'b0);
      rd(ART_OFS_CTRL, 8'h17);
      wr(ART_OFS_IEN, 8'h02);
      check(timer_irq, 1'b1);
      wr(ART_OFS_CTRL, 8'h07);
      check(timer_irq, 1'b0);
      // reload written while running is flagged; masked, so no irq
      wr(ART_OFS_CTRL, 8'h0F);
      wr(ART_OFS_RLD_LO, 8'hFC);
      wr(ART_OFS_CTRL, 8'h07);
      rd(ART_OFS_STAT, 8'h02);
      check(irq, 1'b0);
      wr(ART_OFS_STAT, 8'h02);
      rd(ART_OFS_STAT, 8'h00);
      // every prescale code: reload FFFC gives four steps per lap
      for (int p = 0; p < 8; p++) begin
         wr(ART_OFS_CTRL, 8'h08 | p[7:0]);
         wait_tick(g);
         wait_tick(g);
         check(g, 16'(4 << p));
         wr(ART_OFS_CTRL, p[7:0]);
      end
      // restart from halt: held count FFFC and a cleared prescaler give
      // the first step 4 cycles after run, so one lap is 16 cycles
      wr(ART_OFS_CTRL, 8'h0A);
      wait_tick(g);
      check(g, 16'h0010);
      wr(ART_OFS_CTRL, 8'h02);
      tally_and_finish();
   end

endmodule
